// File: src/port_pin_function_select.sv
`timescale 1ns/1ps
module port_pin_function_select (
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_n_i,
  input  wire logic [pin_select_pkg::ADDR_W-1:0]      addr_i,
  input  wire logic [7:0]                             wr_data_i,
  input  wire logic                                   wr_en_i,
  input  wire logic                                   rd_en_i,
  input  wire pin_select_pkg::gpio_t                  gpio_a_i,
  input  wire pin_select_pkg::gpio_t                  gpio_b_i,
  input  wire pin_select_pkg::gpio_t                  gpio_c_i,
  input  wire pin_select_pkg::periph_t                periph_i,
  output logic [7:0]                                  rd_data_o,
  output pin_select_pkg::pad_t                        pad_a_o,
  output pin_select_pkg::pad_t                        pad_b_o,
  output pin_select_pkg::pad_t                        pad_c_o
);

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic pin_select_pkg::sel_code_t fld(
    input logic [7:0]  r,
    input int unsigned p
  );
    return pin_select_pkg::sel_code_t'(r[p+:2]);
  endfunction

  // Push-pull drive of a peripheral output
  function automatic logic [2:0] push(input logic v);
    return {1'b0, 1'b1, v};
  endfunction

  // Open-drain drive: pull low only
  function automatic logic [2:0] drain(input logic v);
    return {1'b0, ~v, 1'b0};
  endfunction

  // ----------------------------------------------------------
  // Select registers
  // ----------------------------------------------------------
  logic [7:0] port_a_select_low;
  logic [7:0] port_a_select_high;
  logic [7:0] port_b_select_low;
  logic [7:0] port_b_select_high;
  logic [7:0] port_c_select_low;
  logic [7:0] port_c_select_high;
  logic [7:0] next_rd_data;

  // Register writes, fields clear to general I/O
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_a_select_low  <= pin_select_pkg::SEL_RESET;
      port_a_select_high <= pin_select_pkg::SEL_RESET;
      port_b_select_low  <= pin_select_pkg::SEL_RESET;
      port_b_select_high <= pin_select_pkg::SEL_RESET;
      port_c_select_low  <= pin_select_pkg::SEL_RESET;
      port_c_select_high <= pin_select_pkg::SEL_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        pin_select_pkg::OFF_A_LOW:  port_a_select_low  <= wr_data_i;
        pin_select_pkg::OFF_A_HIGH: port_a_select_high <= wr_data_i;
        pin_select_pkg::OFF_B_LOW:  port_b_select_low  <= wr_data_i;
        pin_select_pkg::OFF_B_HIGH: port_b_select_high <= wr_data_i;
        pin_select_pkg::OFF_C_LOW:  port_c_select_low  <= wr_data_i;
        pin_select_pkg::OFF_C_HIGH:
          port_c_select_high <= wr_data_i & pin_select_pkg::C_HIGH_MASK;
        default: ;
      endcase
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    case (addr_i)
      pin_select_pkg::OFF_A_LOW:  next_rd_data = port_a_select_low;
      pin_select_pkg::OFF_A_HIGH: next_rd_data = port_a_select_high;
      pin_select_pkg::OFF_B_LOW:  next_rd_data = port_b_select_low;
      pin_select_pkg::OFF_B_HIGH: next_rd_data = port_b_select_high;
      pin_select_pkg::OFF_C_LOW:  next_rd_data = port_c_select_low;
      pin_select_pkg::OFF_C_HIGH: next_rd_data = port_c_select_high;
      default:                    next_rd_data = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_en_i ? next_rd_data : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // Port A routing
  // ----------------------------------------------------------
  logic [2:0] drv_a [8];
  logic [2:0] drv_b [8];
  logic [2:0] drv_c [8];
  pin_select_pkg::pad_t next_pad_a;
  pin_select_pkg::pad_t next_pad_b;
  pin_select_pkg::pad_t next_pad_c;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drv_a[i] = {1'b0, gpio_a_i.oe[i], gpio_a_i.out[i]};
    end
    // Pin 7
    case (fld(port_a_select_high, pin_select_pkg::POS_A7))
      pin_select_pkg::SEL_ALT1: drv_a[7] = pin_select_pkg::DRV_ANALOG;
      pin_select_pkg::SEL_ALT2: drv_a[7] = drain(periph_i.sda_out);
      pin_select_pkg::SEL_ALT3:
        drv_a[7] = {1'b0, periph_i.uart_rxtx_oe, periph_i.uart_rxtx};
      default: ;
    endcase
    // Pin 6
    case (fld(port_a_select_high, pin_select_pkg::POS_A6))
      pin_select_pkg::SEL_ALT1: drv_a[6] = pin_select_pkg::DRV_ANALOG;
      pin_select_pkg::SEL_ALT2: drv_a[6] = push(periph_i.timer2);
      pin_select_pkg::SEL_ALT3: drv_a[6] = push(periph_i.hall_b);
      default: ;
    endcase
    // Pins 5, 4, 3: comparator and analog in the middle codes
    case (fld(port_a_select_high, pin_select_pkg::POS_A5))
      pin_select_pkg::SEL_ALT1,
      pin_select_pkg::SEL_ALT2: drv_a[5] = pin_select_pkg::DRV_ANALOG;
      default: ;
    endcase
    case (fld(port_a_select_high, pin_select_pkg::POS_A4))
      pin_select_pkg::SEL_ALT1,
      pin_select_pkg::SEL_ALT2: drv_a[4] = pin_select_pkg::DRV_ANALOG;
      default: ;
    endcase
    case (fld(port_a_select_low, pin_select_pkg::POS_A3))
      pin_select_pkg::SEL_ALT1,
      pin_select_pkg::SEL_ALT2: drv_a[3] = pin_select_pkg::DRV_ANALOG;
      default: ;
    endcase
    // Pin 1: every alternate is an analog node
    if (fld(port_a_select_low, pin_select_pkg::POS_A1) != pin_select_pkg::SEL_GPIO) begin
      drv_a[1] = pin_select_pkg::DRV_ANALOG;
    end
  end

  // ----------------------------------------------------------
  // Port B routing
  // ----------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drv_b[i] = {1'b0, gpio_b_i.oe[i], gpio_b_i.out[i]};
    end
    // Pin 1: comparator, common node, analog
    if (fld(port_b_select_low, pin_select_pkg::POS_B1) != pin_select_pkg::SEL_GPIO) begin
      drv_b[1] = pin_select_pkg::DRV_ANALOG;
    end
    // Pin 0
    case (fld(port_b_select_low, pin_select_pkg::POS_B0))
      pin_select_pkg::SEL_ALT1: drv_b[0] = pin_select_pkg::DRV_ANALOG;
      pin_select_pkg::SEL_ALT2: drv_b[0] = drain(periph_i.scl_out);
      pin_select_pkg::SEL_ALT3: drv_b[0] = push(periph_i.uart_tx);
      default: ;
    endcase
    // Pin 6
    case (fld(port_b_select_high, pin_select_pkg::POS_B6))
      pin_select_pkg::SEL_ALT1: drv_b[6] = push(periph_i.timer3);
      pin_select_pkg::SEL_ALT2: drv_b[6] = push(periph_i.timer3_inv);
      pin_select_pkg::SEL_ALT3: drv_b[6] = pin_select_pkg::DRV_ANALOG;
      default: ;
    endcase
    // Pin 5
    case (fld(port_b_select_high, pin_select_pkg::POS_B5))
      pin_select_pkg::SEL_ALT1: drv_b[5] = drain(periph_i.scl_out);
      pin_select_pkg::SEL_ALT2: drv_b[5] = push(periph_i.hall_a);
      pin_select_pkg::SEL_ALT3: drv_b[5] = push(periph_i.uart_tx);
      default: ;
    endcase
    // Pin 4
    case (fld(port_b_select_high, pin_select_pkg::POS_B4))
      pin_select_pkg::SEL_ALT1: drv_b[4] = push(periph_i.timer2);
      pin_select_pkg::SEL_ALT2:
        drv_b[4] = {1'b0, periph_i.uart_rxtx_oe, periph_i.uart_rxtx};
      pin_select_pkg::SEL_ALT3: drv_b[4] = push(periph_i.timer2_inv);
      default: ;
    endcase
  end

  // ----------------------------------------------------------
  // Port C gate-driver lines
  // ----------------------------------------------------------
  logic [5:0]  gate_c;
  logic [11:0] sel_c;

  assign gate_c = {periph_i.gate_cl, periph_i.gate_ch, periph_i.gate_bl,
                   periph_i.gate_bh, 1'b0, periph_i.gate_ah};
  assign sel_c  = {port_c_select_high[3:0], port_c_select_low};

  // Lines 6 and 7 are absent and stay released
  assign drv_c[6] = pin_select_pkg::DRV_OFF;
  assign drv_c[7] = pin_select_pkg::DRV_OFF;

  for (genvar i = 0; i < 6; i++) begin : g_line_c
    if (i == 1) begin : g_plain
      assign drv_c[i] = {1'b0, gpio_c_i.oe[i], gpio_c_i.out[i]};
    end else begin : g_gate
      // Code 01 drives the gate line, reserved codes release it
      always_comb begin
        case (sel_c[2*i+:2])
          pin_select_pkg::SEL_GPIO:
            drv_c[i] = {1'b0, gpio_c_i.oe[i], gpio_c_i.out[i]};
          pin_select_pkg::SEL_ALT1:
            drv_c[i] = push(gate_c[i]);
          default:
            drv_c[i] = pin_select_pkg::DRV_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Pad outputs, registered
  // ----------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pack
    assign next_pad_a.out[i] = drv_a[i][0];
    assign next_pad_a.oe[i]  = drv_a[i][1];
    assign next_pad_a.ana[i] = drv_a[i][2];
    assign next_pad_b.out[i] = drv_b[i][0];
    assign next_pad_b.oe[i]  = drv_b[i][1];
    assign next_pad_b.ana[i] = drv_b[i][2];
    assign next_pad_c.out[i] = drv_c[i][0];
    assign next_pad_c.oe[i]  = drv_c[i][1];
    assign next_pad_c.ana[i] = drv_c[i][2];
  end

  // Pads idle released during reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_a_o <= '0;
      pad_b_o <= '0;
      pad_c_o <= '0;
    end else begin
      pad_a_o <= next_pad_a;
      pad_b_o <= next_pad_b;
      pad_c_o <= next_pad_c;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_a_high;
    wr_en_i && addr_i == pin_select_pkg::OFF_A_HIGH;
  endsequence

  sequence s_rd_a_high;
    rd_en_i && !wr_en_i && addr_i == pin_select_pkg::OFF_A_HIGH;
  endsequence

  a_readback_last: assert property (
    (s_wr_a_high ##1 s_rd_a_high) |=> rd_data_o == $past(wr_data_i, 2))
    else $error("Select register read back wrong value");

  a_c_high_upper: assert property (
    (rd_en_i && addr_i == pin_select_pkg::OFF_C_HIGH) |=> rd_data_o[7:4] == 4'h0)
    else $error("Unimplemented bits read non-zero");

  a_a7_sda_drain: assert property (
    port_a_select_high[7:6] == 2'b10 |=>
      !pad_a_o.out[7] && pad_a_o.oe[7] == !$past(periph_i.sda_out))
    else $error("Port A pin 7 SDA drive wrong");

  a_a6_timer_out: assert property (
    port_a_select_high[5:4] == 2'b10 |=>
      pad_a_o.oe[6] && pad_a_o.out[6] == $past(periph_i.timer2))
    else $error("Port A pin 6 timer2 drive wrong");

  a_a5_gpio_alias: assert property (
    port_a_select_high[3:2] == 2'b11 |=>
      pad_a_o.out[5] == $past(gpio_a_i.out[5]) && !pad_a_o.ana[5])
    else $error("Port A pin 5 code 11 not general I/O");

  a_a4_analog: assert property (
    port_a_select_high[1:0] == 2'b01 |=> pad_a_o.ana[4] && !pad_a_o.oe[4])
    else $error("Port A pin 4 comparator not analog");

  a_a1_analog: assert property (
    port_a_select_low[3:2] != 2'b00 |=> pad_a_o.ana[1] && !pad_a_o.oe[1])
    else $error("Port A pin 1 alternate not analog");

  a_a3_analog: assert property (
    port_a_select_low[7:6] == 2'b10 |=> pad_a_o.ana[3])
    else $error("Port A pin 3 analog not selected");

  a_b1_analog: assert property (
    port_b_select_low[3:2] == 2'b10 |=> pad_b_o.ana[1] && !pad_b_o.oe[1])
    else $error("Port B pin 1 common node wrong");

  a_b0_uart_tx: assert property (
    port_b_select_low[1:0] == 2'b11 |=>
      pad_b_o.oe[0] && pad_b_o.out[0] == $past(periph_i.uart_tx))
    else $error("Port B pin 0 UART TX wrong");

  a_b6_inverted: assert property (
    port_b_select_high[5:4] == 2'b10 |=>
      pad_b_o.oe[6] && pad_b_o.out[6] == $past(periph_i.timer3_inv))
    else $error("Port B pin 6 inverted timer3 wrong");

  a_b5_hall_a: assert property (
    port_b_select_high[3:2] == 2'b10 |=>
      pad_b_o.oe[5] && pad_b_o.out[5] == $past(periph_i.hall_a))
    else $error("Port B pin 5 hall A wrong");

  a_b4_uart_rxtx: assert property (
    port_b_select_high[1:0] == 2'b10 |=>
      pad_b_o.oe[4] == $past(periph_i.uart_rxtx_oe))
    else $error("Port B pin 4 UART enable wrong");

  a_c3_gate_low: assert property (
    port_c_select_low[7:6] == 2'b01 |=>
      pad_c_o.oe[3] && pad_c_o.out[3] == $past(periph_i.gate_bl))
    else $error("Port C line 3 gate wrong");

  a_c2_reserved: assert property (
    port_c_select_low[5:4] inside {2'b10, 2'b11} |=> !pad_c_o.oe[2])
    else $error("Port C line 2 reserved code drives");

  a_c0_gate_high: assert property (
    port_c_select_low[1:0] == 2'b01 |=>
      pad_c_o.out[0] == $past(periph_i.gate_ah))
    else $error("Port C line 0 gate wrong");

  a_c5_gate_low: assert property (
    port_c_select_high[3:2] == 2'b01 |=>
      pad_c_o.out[5] == $past(periph_i.gate_cl))
    else $error("Port C line 5 gate wrong");

  a_c4_gate_high: assert property (
    port_c_select_high[1:0] == 2'b01 |=>
      pad_c_o.out[4] == $past(periph_i.gate_ch))
    else $error("Port C line 4 gate wrong");

  a_a7_uart_pin: assert property (
    port_a_select_high[7:6] == 2'b11 |=>
      pad_a_o.out[7] == $past(periph_i.uart_rxtx) &&
      pad_a_o.oe[7] == $past(periph_i.uart_rxtx_oe))
    else $error("Port A pin 7 UART drive wrong");

  a_a6_hall_b: assert property (
    port_a_select_high[5:4] == 2'b11 |=>
      pad_a_o.oe[6] && pad_a_o.out[6] == $past(periph_i.hall_b))
    else $error("Port A pin 6 hall B drive wrong");

  a_b0_scl_drain: assert property (
    port_b_select_low[1:0] == 2'b10 |=>
      !pad_b_o.out[0] && pad_b_o.oe[0] == !$past(periph_i.scl_out))
    else $error("Port B pin 0 SCL drive wrong");

  a_b5_scl_drain: assert property (
    port_b_select_high[3:2] == 2'b01 |=>
      !pad_b_o.out[5] && pad_b_o.oe[5] == !$past(periph_i.scl_out))
    else $error("Port B pin 5 SCL drive wrong");

  a_b6_opamp_out: assert property (
    port_b_select_high[5:4] == 2'b11 |=> pad_b_o.ana[6] && !pad_b_o.oe[6])
    else $error("Port B pin 6 op-amp output not analog");

  // Sampled reset keeps the release edge, where pads still show reset, out
  a_gpio_default: assert property (
    rst_n_i && port_a_select_high[7:6] == 2'b00 |=>
      pad_a_o.out[7] == $past(gpio_a_i.out[7]) &&
      pad_a_o.oe[7] == $past(gpio_a_i.oe[7]) && !pad_a_o.ana[7])
    else $error("Port A pin 7 code 00 not general I/O");

  a_rd_idle_zero: assert property (
    !rd_en_i |=> rd_data_o == 8'h00)
    else $error("Read data stands outside its cycle");

endmodule

// File: src/pin_select_pkg.sv
// How it works
// - Port A pin 7 field picks I/O/analog/SDA/UART
// - Port A pin 6 field picks I/O/analog/timer2/hall B
// - Port A pin 5: I/O twice, comparator, analog
// - Port A pin 4: I/O twice, comparator, analog
// - Port A pin 1: I/O, analog, reference, op-amp
// - Port A pin 3: I/O twice, comparator, analog
// - Port B pin 1: I/O, comparator, common node, analog
// - Port B pin 0: I/O, analog, SCL, UART TX
// - Port B pin 6: I/O, timer3, inverted, op-amp out
// - Port B pin 5: I/O, SCL, hall A, UART TX
// - Port B pin 4: I/O, timer2, UART, inverted timer2
// - Port C line 3: I/O or phase B low gate
// - Port C line 2: I/O or phase B high gate
// - Port C line 0: I/O or phase A high gate
// - Port C line 5: I/O or phase C low gate
// - Port C line 4: I/O or phase C high gate
package pin_select_pkg;

  // ----------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------
  localparam int unsigned ADDR_W      = 3;
  localparam logic [2:0]  OFF_A_LOW   = 3'h0;
  localparam logic [2:0]  OFF_A_HIGH  = 3'h1;
  localparam logic [2:0]  OFF_B_LOW   = 3'h2;
  localparam logic [2:0]  OFF_B_HIGH  = 3'h3;
  localparam logic [2:0]  OFF_C_LOW   = 3'h4;
  localparam logic [2:0]  OFF_C_HIGH  = 3'h5;
  localparam logic [7:0]  SEL_RESET   = 8'h00;
  localparam logic [7:0]  C_HIGH_MASK = 8'h0F;

  // ----------------------------------------------------------
  // Field positions (low bit of each 2-bit field)
  // ----------------------------------------------------------
  localparam int unsigned POS_A7 = 6;
  localparam int unsigned POS_A6 = 4;
  localparam int unsigned POS_A5 = 2;
  localparam int unsigned POS_A4 = 0;
  localparam int unsigned POS_A3 = 6;
  localparam int unsigned POS_A1 = 2;
  localparam int unsigned POS_B6 = 4;
  localparam int unsigned POS_B5 = 2;
  localparam int unsigned POS_B4 = 0;
  localparam int unsigned POS_B1 = 2;
  localparam int unsigned POS_B0 = 0;

  // Pad drive {analog, oe, out}
  localparam logic [2:0] DRV_ANALOG = 3'h4;
  localparam logic [2:0] DRV_OFF    = 3'h0;

  typedef enum logic [1:0] {
    SEL_GPIO = 2'h0,
    SEL_ALT1 = 2'h1,
    SEL_ALT2 = 2'h2,
    SEL_ALT3 = 2'h3
  } sel_code_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpio_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] ana;
  } pad_t;

  typedef struct packed {
    logic timer2;
    logic timer2_inv;
    logic timer3;
    logic timer3_inv;
    logic hall_a;
    logic hall_b;
    logic sda_out;
    logic scl_out;
    logic uart_tx;
    logic uart_rxtx;
    logic uart_rxtx_oe;
    logic gate_ah;
    logic gate_bh;
    logic gate_bl;
    logic gate_ch;
    logic gate_cl;
  } periph_t;

endpackage

// File: testbench/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  input  wire logic               clock_i,
  input  wire logic               quiet_i,
  output pin_select_pkg::periph_t periph_o,
  output pin_select_pkg::gpio_t   gpio_a_o,
  output pin_select_pkg::gpio_t   gpio_b_o,
  output pin_select_pkg::gpio_t   gpio_c_o
);
  integer seed = 58047;

  // Defined levels before the first edge
  initial begin
    periph_o = '0;
    gpio_a_o = '0;
    gpio_b_o = '0;
    gpio_c_o = '0;
  end

  // ----------------------------------------------------------
  // Peripheral and port latch activity
  // ----------------------------------------------------------
  // Fresh levels after every edge, or all idle while quiet
  always @(posedge clock_i) begin
    if (quiet_i) begin
      periph_o <= '0;
      gpio_a_o <= '0;
      gpio_b_o <= '0;
      gpio_c_o <= '0;
    end else begin
      periph_o <= 16'($random(seed));
      gpio_a_o <= 16'($random(seed));
      gpio_b_o <= 16'($random(seed));
      gpio_c_o <= 16'($random(seed));
    end
  end
endmodule

// File: testbench/port_pin_function_select_tb.sv
`timescale 1ns/1ps
module port_pin_function_select_tb;
  localparam logic [2:0] AN  = 3'h4;
  localparam logic [2:0] NIL = 3'h0;

  logic                                clock_i;
  logic                                rst_n_i;
  logic [pin_select_pkg::ADDR_W-1:0]   addr_i;
  logic [7:0]                          wr_data_i;
  logic                                wr_en_i;
  logic                                rd_en_i;
  logic                                quiet;
  logic [7:0]                          rd_data_o;
  pin_select_pkg::gpio_t               ga;
  pin_select_pkg::gpio_t               gb;
  pin_select_pkg::gpio_t               gc;
  pin_select_pkg::periph_t             pf;
  pin_select_pkg::pad_t                pad_a_o;
  pin_select_pkg::pad_t                pad_b_o;
  pin_select_pkg::pad_t                pad_c_o;
  pin_select_pkg::pad_t                exp_a;
  pin_select_pkg::pad_t                exp_b;
  pin_select_pkg::pad_t                exp_c;
  logic [7:0]                          exp_rd;
  logic [7:0]                          regs [6];
  logic [7:0]                          b;
  logic [7:0]                          d;
  logic [2:0]                          a;
  logic [1:0]                          op;
  integer                              seed = 58047;
  integer                              miscompares = 0;
  integer                              checks_done = 0;

  port_pin_function_select port_pin_function_select_i (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .addr_i    (addr_i),
    .wr_data_i (wr_data_i),
    .wr_en_i   (wr_en_i),
    .rd_en_i   (rd_en_i),
    .gpio_a_i  (ga),
    .gpio_b_i  (gb),
    .gpio_c_i  (gc),
    .periph_i  (pf),
    .rd_data_o (rd_data_o),
    .pad_a_o   (pad_a_o),
    .pad_b_o   (pad_b_o),
    .pad_c_o   (pad_c_o)
  );

  periph_model periph_model_i (
    .clock_i  (clock_i),
    .quiet_i  (quiet),
    .periph_o (pf),
    .gpio_a_o (ga),
    .gpio_b_o (gb),
    .gpio_c_o (gc)
  );

  // ----------------------------------------------------------
  // Reference model helpers, triples are {analog, oe, out}
  // ----------------------------------------------------------
  function automatic logic [2:0] pick(logic [1:0] c, logic [3:0][2:0] f);
    return f[c];
  endfunction

  function automatic logic [2:0] gp(pin_select_pkg::gpio_t g, int n);
    return {1'b0, g.oe[n], g.out[n]};
  endfunction

  function automatic logic [2:0] pp(logic s);
    return {2'h1, s};
  endfunction

  function automatic logic [2:0] od(logic s);
    return {1'b0, ~s, 1'b0};
  endfunction

  function automatic pin_select_pkg::pad_t pack8(logic [7:0][2:0] t);
    pin_select_pkg::pad_t p;
    for (int n = 0; n < 8; n++) begin
      p.ana[n] = t[n][2];
      p.oe[n]  = t[n][1];
      p.out[n] = t[n][0];
    end
    return p;
  endfunction

  // Register file, read data and pad drive one edge behind
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 6; i++) regs[i] <= 8'h00;
      exp_rd <= 8'h00;
      exp_a  <= '0;
      exp_b  <= '0;
      exp_c  <= '0;
    end else begin
      exp_rd <= (rd_en_i && addr_i < 3'h6) ? regs[addr_i] : 8'h00;
      if (wr_en_i && addr_i < 3'h6)
        regs[addr_i] <= (addr_i == 3'h5) ? (wr_data_i & 8'h0F) : wr_data_i;
      exp_a <= pack8({pick(regs[1][7:6], {{1'b0, pf.uart_rxtx_oe, pf.uart_rxtx},
                                           od(pf.sda_out), AN, gp(ga, 7)}),
                      pick(regs[1][5:4], {pp(pf.hall_b), pp(pf.timer2), AN, gp(ga, 6)}),
                      pick(regs[1][3:2], {gp(ga, 5), AN, AN, gp(ga, 5)}),
                      pick(regs[1][1:0], {gp(ga, 4), AN, AN, gp(ga, 4)}),
                      pick(regs[0][7:6], {gp(ga, 3), AN, AN, gp(ga, 3)}),
                      gp(ga, 2),
                      pick(regs[0][3:2], {AN, AN, AN, gp(ga, 1)}),
                      gp(ga, 0)});
      exp_b <= pack8({gp(gb, 7),
                      pick(regs[3][5:4], {AN, pp(pf.timer3_inv), pp(pf.timer3), gp(gb, 6)}),
                      pick(regs[3][3:2], {pp(pf.uart_tx), pp(pf.hall_a), od(pf.scl_out),
                                          gp(gb, 5)}),
                      pick(regs[3][1:0], {pp(pf.timer2_inv),
                                          {1'b0, pf.uart_rxtx_oe, pf.uart_rxtx},
                                          pp(pf.timer2), gp(gb, 4)}),
                      gp(gb, 3),
                      gp(gb, 2),
                      pick(regs[2][3:2], {AN, AN, AN, gp(gb, 1)}),
                      pick(regs[2][1:0], {pp(pf.uart_tx), od(pf.scl_out), AN, gp(gb, 0)})});
      exp_c <= pack8({NIL,
                      NIL,
                      pick(regs[5][3:2], {NIL, NIL, pp(pf.gate_cl), gp(gc, 5)}),
                      pick(regs[5][1:0], {NIL, NIL, pp(pf.gate_ch), gp(gc, 4)}),
                      pick(regs[4][7:6], {NIL, NIL, pp(pf.gate_bl), gp(gc, 3)}),
                      pick(regs[4][5:4], {NIL, NIL, pp(pf.gate_bh), gp(gc, 2)}),
                      gp(gc, 1),
                      pick(regs[4][1:0], {NIL, NIL, pp(pf.gate_ah), gp(gc, 0)})});
    end
  end

  // ----------------------------------------------------------
  // Comparison, bus and closing tasks
  // ----------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [2:0] ad, input logic [7:0] dd);
    @(posedge clock_i);
    wr_en_i   <= w;
    rd_en_i   <= r;
    addr_i    <= ad;
    wr_data_i <= dd;
  endtask

  task automatic read_all;
    for (int i = 0; i < 8; i++) bus(1'b0, 1'b1, 3'(i), 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Every result compared once settled
  always @(negedge clock_i) begin
    check({16'h0000, rd_data_o}, {16'h0000, exp_rd});
    check(pad_a_o, exp_a);
    check(pad_b_o, exp_b);
    check(pad_c_o, exp_c);
  end

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // Hang guard
  initial begin
    repeat (3000) @(posedge clock_i);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish;
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    rst_n_i   = 1'b0;
    wr_en_i   = 1'b0;
    rd_en_i   = 1'b0;
    addr_i    = 3'h0;
    wr_data_i = 8'h00;
    quiet     = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    read_all;
    $display("Test reset_values done");
    for (int c = 0; c < 4; c++) begin
      quiet <= 1'b1;
      b = {4{2'(c)}};
      bus(1'b1, 1'b0, 3'h0, b);
      bus(1'b1, 1'b0, 3'h1, b);
      bus(1'b1, 1'b0, 3'h2, {4'h0, b[3:0]});
      bus(1'b1, 1'b0, 3'h3, {2'h0, b[5:0]});
      bus(1'b1, 1'b0, 3'h4, b);
      bus(1'b1, 1'b0, 3'h5, b);
      quiet <= 1'b0;
      repeat (12) bus(1'b0, 1'b0, 3'h0, 8'h00);
      read_all;
    end
    $display("Test all_codes done");
    repeat (400) begin
      op = 2'($random(seed));
      a  = 3'($random(seed));
      d  = 8'($random(seed));
      if (a == 3'h2) d[7:4] = 4'h0;
      if (a == 3'h3) d[7:6] = 2'h0;
      bus(op[0], op[1] & ~op[0], a, d);
    end
    bus(1'b1, 1'b0, 3'h1, 8'hA5);
    bus(1'b0, 1'b1, 3'h1, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    $display("Test random_traffic done");
    for (int i = 0; i < 6; i++)
      bus(1'b1, 1'b0, 3'(i), (i == 2) ? 8'h0F : (i == 3) ? 8'h3F : 8'hFF);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    read_all;
    repeat (4) @(posedge clock_i);
    $display("Test mid_run_reset done");
    tally_and_finish;
  end
endmodule
